//--- pkg/utxbc_map.svh
// Register offsets, field positions, reset values and frame counts
`ifndef UTXBC_MAP_SVH
`define UTXBC_MAP_SVH

// Register byte offsets on the APB bus
`define UTXBC_DATA_OFS   8'h00
`define UTXBC_TSR_OFS    8'h04
`define UTXBC_SCR_OFS    8'h08
`define UTXBC_CTRL_OFS   8'h0c
`define UTXBC_RSR_OFS    8'h10
`define UTXBC_ISTAT_OFS  8'h14
`define UTXBC_IMASK_OFS  8'h18

// Control register fields
`define UTXBC_CTRL_SYNC  0
`define UTXBC_CTRL_RXON  1

// Interrupt status and mask fields
`define UTXBC_INT_W      5
`define UTXBC_INT_BE     0
`define UTXBC_INT_UE     1
`define UTXBC_INT_END    2
`define UTXBC_INT_BRK    3
`define UTXBC_INT_OVR    4

// Reset values
`define UTXBC_TSR_RST    8'h80
`define UTXBC_SCR_RST    8'h00

// Bit counts of one character on the line
`define UTXBC_ASYNC_BITS 4'ha
`define UTXBC_SYNC_BITS  4'h8

`endif

//--- pkg/utxbc_pkg.sv
// Types shared by the transmitter and break control block
package utxbc_pkg;

	// Shifter state: stopped or running on the shift clock
	typedef enum logic [0:0] {
		UTXBC_OFF = 1'b0,
		UTXBC_RUN = 1'b1
	} utxbc_state_t;

	// What the shift register currently holds
	typedef enum logic [1:0] {
		UTXBC_K_IDLE = 2'b00,
		UTXBC_K_DATA = 2'b01,
		UTXBC_K_BRK  = 2'b10
	} utxbc_kind_t;

	// Transmitter status and control, in register bit order 7..0
	typedef struct packed {
		logic tx_holding_vacant;
		logic tx_starved_flag;
		logic auto_turnaround;
		logic fin;
		logic brk;
		logic hi;
		logic lo;
		logic tx_on;
	} utxbc_tsr_t;

	// Receiver buffer flags
	typedef struct packed {
		logic full;
		logic ovr;
		logic brk;
		logic ovr_pend;
		logic brk_pend;
	} utxbc_rx_t;

endpackage

//--- hdl/utxbc_top.sv
// USART transmitter with break control and receiver flag rules
// Operation
// - Break into full buffer: break flag after read
// - Overrun then break: both flags on read
// - Data write loads buffer; moves set empty
// - Shifter done with empty buffer: underrun
// - Idle: mark in async, sync char otherwise
// - One bit precedes first word after enable
// - Disable: finish word, keep buffered word
// - Disable with empty buffer: no underrun
// - Idle disable halts at next shift edge
// - Break (async mode only) starts after current word, until cleared
// - End event at every break character boundary
// - Buffered char follows break; empty means underrun
// - Disable mid-break: stop, no empty/underrun
// - Flags update regardless of interrupt masks
// - Auto-turnaround enables receiver after last char
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "utxbc_map.svh"

module utxbc_top
	import utxbc_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              tc_i,
	input  wire logic              rx_word_stb_i,
	input  wire logic [7:0]        rx_word_i,
	input  wire logic              rx_break_stb_i,
	output logic                   so_o,
	output logic                   so_oe_n_o,
	output logic                   loopback_o,
	output logic                   rx_on_o,
	output logic                   irq_o
);

	// The shifter and the character framing are fixed at one byte
	if (DATA_W != 8 || ADDR_W < 8) begin : g_param_chk
		$error("utxbc_top: DATA_W must be 8 and ADDR_W at least 8");
	end

	// Shift clock synchroniser; only stage two and three feed the edge
	logic tc_s1_r, tc_s2_r, tc_s3_r;
	logic tick;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			{tc_s3_r, tc_s2_r, tc_s1_r} <= 3'b000;
		else
			{tc_s3_r, tc_s2_r, tc_s1_r} <= {tc_s2_r, tc_s1_r, tc_i};
	end

	assign tick = tc_s2_r & ~tc_s3_r;

	// State registers and their next values
	utxbc_tsr_t         tsr_r, tsr_nxt;
	utxbc_rx_t          rx_r, rx_nxt;
	utxbc_state_t       state_r, state_nxt;
	utxbc_kind_t        kind_r, kind_nxt;
	logic [7:0]         hold_r, hold_nxt;
	logic [9:0]         shf_r, shf_nxt;
	logic [3:0]         cnt_r, cnt_nxt;
	logic [7:0]         scr_r, scr_nxt;
	logic [7:0]         rbuf_r, rbuf_nxt;
	logic               sync_r, sync_nxt;
	logic               rxon_r, rxon_nxt;
	logic [`UTXBC_INT_W-1:0] ist_r, ist_nxt;
	logic [`UTXBC_INT_W-1:0] imsk_r, imsk_nxt;
	logic [`UTXBC_INT_W-1:0] evt;
	logic [31:0]        prdata_r, prdata_nxt;
	logic               pready_r, pready_nxt;
	logic               pslverr_r, pslverr_nxt;
	logic               irq_r, irq_nxt;
	logic               so_r, so_nxt;
	logic               oe_n_r, oe_n_nxt;
	logic               loop_r, loop_nxt;

	// Bus decode
	logic       acc, wr, rd, hit, bound;
	logic [7:0] a;

	assign a   = paddr_i[7:0];
	assign acc = psel_i & penable_i & pready_r;
	assign wr  = acc & pwrite_i & ~pslverr_r;
	assign rd  = acc & ~pwrite_i & ~pslverr_r;
	assign hit = (a == `UTXBC_DATA_OFS) || (a == `UTXBC_TSR_OFS) ||
		(a == `UTXBC_SCR_OFS) || (a == `UTXBC_CTRL_OFS) ||
		(a == `UTXBC_RSR_OFS) || (a == `UTXBC_ISTAT_OFS) ||
		(a == `UTXBC_IMASK_OFS);

	// Character boundary: last bit out, or idle fill may be cut short
	assign bound = tick && state_r == UTXBC_RUN && (cnt_r == 4'h1 ||
		(kind_r == UTXBC_K_IDLE && !tsr_r.tx_on));

	// Next-state logic for the whole block
	always_comb begin
		tsr_nxt     = tsr_r;
		rx_nxt      = rx_r;
		state_nxt   = state_r;
		kind_nxt    = kind_r;
		hold_nxt    = hold_r;
		shf_nxt     = shf_r;
		cnt_nxt     = cnt_r;
		scr_nxt     = scr_r;
		rbuf_nxt    = rbuf_r;
		sync_nxt    = sync_r;
		rxon_nxt    = rxon_r;
		imsk_nxt    = imsk_r;
		evt         = '0;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		// Zero-wait answer: ready in the first access cycle
		pready_nxt  = psel_i & ~penable_i & ~pready_r;

		// Read data is captured in the setup cycle
		if (psel_i && !penable_i) begin
			pslverr_nxt = ~hit;
			unique case (a)
			`UTXBC_DATA_OFS:  prdata_nxt = {24'h0, rbuf_r};
			`UTXBC_TSR_OFS:   prdata_nxt = {24'h0, tsr_r};
			`UTXBC_SCR_OFS:   prdata_nxt = {24'h0, scr_r};
			`UTXBC_CTRL_OFS:  prdata_nxt = {30'h0, rxon_r, sync_r};
			`UTXBC_RSR_OFS:   prdata_nxt = {29'h0, rx_r.brk, rx_r.ovr,
				rx_r.full};
			`UTXBC_ISTAT_OFS: prdata_nxt = {27'h0, ist_r};
			`UTXBC_IMASK_OFS: prdata_nxt = {27'h0, imsk_r};
			default:          prdata_nxt = 32'h0;
			endcase
		end

		// Register side effects: the clears come first so events win
		if (rd && a == `UTXBC_TSR_OFS)
			tsr_nxt.tx_starved_flag = 1'b0;
		if (rd && a == `UTXBC_RSR_OFS) begin
			rx_nxt.ovr = 1'b0;
			rx_nxt.brk = 1'b0;
		end
		if (rd && a == `UTXBC_DATA_OFS && rx_r.full) begin
			rx_nxt.full     = 1'b0;
			rx_nxt.brk_pend = 1'b0;
			rx_nxt.ovr_pend = 1'b0;
			rx_nxt.brk          = rx_nxt.brk | rx_r.brk_pend;
			rx_nxt.ovr          = rx_nxt.ovr | rx_r.ovr_pend;
			evt[`UTXBC_INT_BRK] = rx_r.brk_pend;
			evt[`UTXBC_INT_OVR] = rx_r.ovr_pend;
		end
		if (wr) begin
			unique case (a)
			`UTXBC_DATA_OFS: begin
				hold_nxt = pwdata_i[7:0];
				tsr_nxt.tx_holding_vacant = 1'b0;
			end
			`UTXBC_TSR_OFS: begin
				tsr_nxt.auto_turnaround = pwdata_i[5];
				tsr_nxt.brk             = pwdata_i[3];
				tsr_nxt.hi              = pwdata_i[2];
				tsr_nxt.lo              = pwdata_i[1];
				tsr_nxt.tx_on           = pwdata_i[0];
				if (pwdata_i[0])
					tsr_nxt.fin = 1'b0;
				else
					tsr_nxt.tx_starved_flag = 1'b0;
			end
			`UTXBC_SCR_OFS: scr_nxt = pwdata_i[7:0];
			`UTXBC_CTRL_OFS: begin
				sync_nxt = pwdata_i[`UTXBC_CTRL_SYNC];
				rxon_nxt = pwdata_i[`UTXBC_CTRL_RXON];
				if (!pwdata_i[`UTXBC_CTRL_RXON])
					rx_nxt = '0;
			end
			`UTXBC_IMASK_OFS: imsk_nxt = pwdata_i[`UTXBC_INT_W-1:0];
			default: ;
			endcase
		end

		// Receiver buffer: a break or overrun into a full buffer is held back; the word is dropped
		if (rxon_r && rx_word_stb_i) begin
			if (!rx_nxt.full) begin
				rx_nxt.full = 1'b1;
				rbuf_nxt    = rx_word_i;
			end else begin
				rx_nxt.ovr_pend = 1'b1;
			end
		end
		if (rxon_r && rx_break_stb_i) begin
			if (rx_nxt.full) begin
				rx_nxt.brk_pend = 1'b1;
			end else begin
				rx_nxt.brk         = 1'b1;
				evt[`UTXBC_INT_BRK] = 1'b1;
			end
		end

		// Shifter: start on the first shift edge after enabling
		if (state_r == UTXBC_OFF) begin
			if (tick && tsr_r.tx_on) begin
				state_nxt = UTXBC_RUN;
				kind_nxt  = UTXBC_K_IDLE;
				shf_nxt   = 10'h001;
				cnt_nxt   = 4'h1;
			end
		end else if (bound) begin
			if (kind_r == UTXBC_K_BRK) begin
				tsr_nxt.fin         = 1'b1;
				evt[`UTXBC_INT_END] = 1'b1;
			end
			if (!tsr_r.tx_on) begin
				// Halt; buffered word stays, no empty or underrun
				state_nxt   = UTXBC_OFF;
				kind_nxt    = UTXBC_K_IDLE;
				tsr_nxt.fin = 1'b1;
				evt[`UTXBC_INT_END] = 1'b1;
				if (tsr_r.auto_turnaround)
					rxon_nxt = 1'b1;
			end else if (tsr_r.brk && !sync_r) begin
				kind_nxt = UTXBC_K_BRK;
				shf_nxt  = 10'h000;
				cnt_nxt  = `UTXBC_ASYNC_BITS;
			end else if (!tsr_nxt.tx_holding_vacant) begin
				// Move into the shifter, freeing the buffer
				kind_nxt = UTXBC_K_DATA;
				tsr_nxt.tx_holding_vacant = 1'b1;
				evt[`UTXBC_INT_BE] = 1'b1;
				shf_nxt = sync_r ? {2'b11, hold_nxt} :
					{1'b1, hold_nxt, 1'b0};
				cnt_nxt = sync_r ? `UTXBC_SYNC_BITS :
					`UTXBC_ASYNC_BITS;
			end else begin
				// Nothing to send: idle fill, underrun once per gap
				if (kind_r != UTXBC_K_IDLE) begin
					tsr_nxt.tx_starved_flag = 1'b1;
					evt[`UTXBC_INT_UE]      = 1'b1;
				end
				kind_nxt = UTXBC_K_IDLE;
				shf_nxt = sync_r ? {2'b11, scr_r} : 10'h3ff;
				cnt_nxt = sync_r ? `UTXBC_SYNC_BITS : 4'h1;
			end
		end else if (tick) begin
			shf_nxt = {1'b1, shf_r[9:1]};
			cnt_nxt = cnt_r - 4'h1;
		end

		// Sticky status, write one to clear; a new event wins
		ist_nxt = ist_r | evt;
		if (wr && a == `UTXBC_ISTAT_OFS)
			ist_nxt = (ist_r & ~pwdata_i[`UTXBC_INT_W-1:0]) | evt;
		irq_nxt = |(ist_nxt & imsk_nxt);

		// Line drive: shifter while running, else the forced level, or released when both levels are clear
		loop_nxt = 1'b0;
		if (state_nxt == UTXBC_RUN) begin
			so_nxt   = shf_nxt[0];
			oe_n_nxt = 1'b0;
		end else begin
			unique case ({tsr_nxt.hi, tsr_nxt.lo})
			2'b00: {so_nxt, oe_n_nxt, loop_nxt} = 3'b110;
			2'b01: {so_nxt, oe_n_nxt, loop_nxt} = 3'b000;
			2'b10: {so_nxt, oe_n_nxt, loop_nxt} = 3'b100;
			2'b11: {so_nxt, oe_n_nxt, loop_nxt} = 3'b101;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tsr_r     <= `UTXBC_TSR_RST;
			rx_r      <= '0;
			state_r   <= UTXBC_OFF;
			kind_r    <= UTXBC_K_IDLE;
			hold_r    <= 8'h00;
			shf_r     <= 10'h3ff;
			cnt_r     <= 4'h0;
			scr_r     <= `UTXBC_SCR_RST;
			rbuf_r    <= 8'h00;
			sync_r    <= 1'b0;
			rxon_r    <= 1'b0;
			ist_r     <= '0;
			imsk_r    <= '0;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r     <= 1'b0;
			so_r      <= 1'b1;
			oe_n_r    <= 1'b1;
			loop_r    <= 1'b0;
		end else begin
			tsr_r     <= tsr_nxt;
			rx_r      <= rx_nxt;
			state_r   <= state_nxt;
			kind_r    <= kind_nxt;
			hold_r    <= hold_nxt;
			shf_r     <= shf_nxt;
			cnt_r     <= cnt_nxt;
			scr_r     <= scr_nxt;
			rbuf_r    <= rbuf_nxt;
			sync_r    <= sync_nxt;
			rxon_r    <= rxon_nxt;
			ist_r     <= ist_nxt;
			imsk_r    <= imsk_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r     <= irq_nxt;
			so_r      <= so_nxt;
			oe_n_r    <= oe_n_nxt;
			loop_r    <= loop_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata_o   = prdata_r;
	assign pready_o   = pready_r;
	assign pslverr_o  = pslverr_r;
	assign so_o       = so_r;
	assign so_oe_n_o  = oe_n_r;
	assign loopback_o = loop_r;
	assign rx_on_o    = rxon_r;
	assign irq_o      = irq_r;

endmodule // utxbc_top

//--- bench/utxbc_assertions.sv
// Port-level checks for the transmitter and break control block
`timescale 1ns/1ps
module utxbc_checker (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic        tc_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	input  wire logic        so_o,
	input  wire logic        so_oe_n_o,
	input  wire logic        loopback_o,
	input  wire logic        rx_on_o
);
	logic       tc_r;
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;

	// Cycles since a shift clock edge or bus write; saturates at 15
	always_comb begin
		quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
		if ((tc_i && !tc_r) || (psel_i && penable_i && pwrite_i))
			quiet_nxt = 4'h0;
	end

	// Registers only; pin is sampled once so the count runs a bit early
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tc_r    <= 1'b0;
			quiet_r <= 4'hf;
		end else begin
			tc_r    <= tc_i;
			quiet_r <= quiet_nxt;
		end
	end

	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ready_after_setup_a: assert property (
		psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("no single ready pulse after setup");
	ready_cause_a: assert property (
		pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without a setup cycle");
	err_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error flag outside ready");
	err_data_zero_a: assert property (pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read returned data");
	loop_high_a: assert property (
		loopback_o |-> !so_oe_n_o && so_o)
		else $error("loopback line not driven high");
	hiz_no_loop_a: assert property (so_oe_n_o |-> !loopback_o)
		else $error("loopback while line released");
	line_quiet_a: assert property (
		$changed(so_o) |-> quiet_r < 4'h8)
		else $error("serial line moved without a shift edge");
	rx_off_cause_a: assert property (
		$fell(rx_on_o) |-> $past(psel_i && penable_i && pwrite_i))
		else $error("receiver disabled without a bus write");
endmodule // utxbc_checker

bind utxbc_top utxbc_checker utxbc_checker_i (
	.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .tc_i(tc_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.so_o(so_o), .so_oe_n_o(so_oe_n_o), .loopback_o(loopback_o),
	.rx_on_o(rx_on_o));

//--- bench/utxbc_rx_model.sv
// Remote serial receiver: makes the bit clock and frames async words
`timescale 1ns/1ps
module utxbc_rx_model (
	output logic       tc_o,
	input  wire logic  so_i,
	input  wire logic  so_oe_n_i,
	output logic       stb_o,
	output logic       brk_o,
	output logic [7:0] byte_o
);
	int         cnt;
	logic [8:0] sh;

	// Bit clock runs free: idle marks are shifted out on it as well
	initial begin
		tc_o = 1'b0;
		forever #200 tc_o = ~tc_o;
	end

	// A rising edge sees the bit launched by the previous one
	initial begin
		cnt = 0;
		sh = 9'h0;
		{stb_o, brk_o, byte_o} = 10'h0;
		forever begin
			@(posedge tc_o);
			stb_o = 1'b0;
			brk_o = 1'b0;
			if (so_oe_n_i !== 1'b0) begin
				cnt = 0;
			end else if (cnt == 0) begin
				if (so_i === 1'b0) cnt = 1;
			end else begin
				sh = {so_i, sh[8:1]};
				cnt++;
				if (cnt == 10) begin
					cnt = 0;
					byte_o = sh[7:0];
					if (sh[8] === 1'b1) stb_o = 1'b1;
					else if (sh[7:0] === 8'h00) brk_o = 1'b1;
				end
			end
		end
	end
endmodule // utxbc_rx_model

//--- bench/test_usart_transmitter_break_control.sv
// Self-checking bench: APB host, serial receiver model, result monitor
`timescale 1ns/1ps
`include "utxbc_map.svh"
module test_usart_transmitter_break_control;
	localparam logic [7:0] DAT = `UTXBC_DATA_OFS;
	localparam logic [7:0] TRANSMITTER_STATUS_CONTROL = `UTXBC_TSR_OFS;
	localparam logic [7:0] SCR = `UTXBC_SCR_OFS;
	localparam logic [7:0] CTL = `UTXBC_CTRL_OFS;
	localparam logic [7:0] RSR = `UTXBC_RSR_OFS;
	localparam logic [7:0] IST = `UTXBC_ISTAT_OFS;
	localparam logic [7:0] IMK = `UTXBC_IMASK_OFS;
	logic        clk_i, rst_i, psel, penable, pwrite, tc, rx_stb, rx_brk;
	logic        so, so_oe_n, lb, rx_on, irq, pready, pslverr, stb, brk;
	logic [7:0]  paddr, rx_word, rx_byte, b;
	logic [31:0] pwdata, prdata;
	logic [64:0] nt;
	logic [64:0] rq[$];
	logic [7:0]  bq[$];
	logic [1:0]  hl[4] = '{2'b01, 2'b00, 2'b10, 2'b11};
	int          mismatches, checks_done, brk_cnt;

	utxbc_top utxbc_top_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .tc_i(tc), .rx_word_stb_i(rx_stb),
		.rx_word_i(rx_word), .rx_break_stb_i(rx_brk), .so_o(so),
		.so_oe_n_o(so_oe_n), .loopback_o(lb), .rx_on_o(rx_on), .irq_o(irq));
	utxbc_rx_model utxbc_rx_model_i (.tc_o(tc), .so_i(so),
		.so_oe_n_i(so_oe_n), .stb_o(stb), .brk_o(brk), .byte_o(rx_byte));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One transfer; the note is queued before the request goes out
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, m, input logic e);
		rq.push_back(w ? {e, 64'h0} : {e, m, d});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= w ? d : $urandom;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, d);
		apb(1'b0, a, d, m, 1'b0);
	endtask

	// Receiver event pulse, one clock wide
	task automatic rxp(input logic [7:0] w, input logic br);
		rx_word <= w;
		rx_stb  <= !br;
		rx_brk  <= br;
		@(posedge clk_i);
		rx_stb  <= 1'b0;
		rx_brk  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic gap();
		@(posedge stb);
		repeat (20) @(posedge clk_i);
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk_i);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Bus answers and received words against the oldest note
	always @(posedge clk_i) begin
		if (pready === 1'b1 && psel && penable) begin
			nt = rq.pop_front();
			chk("prdata", nt[31:0], prdata & nt[63:32]);
			chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
		end
	end
	always @(posedge stb) begin
		if (bq.size() == 0) chk("rx_extra", 32'h0, 32'h1);
		else chk("rx_byte", {24'h0, bq.pop_front()}, {24'h0, rx_byte});
	end
	always @(posedge brk) brk_cnt++;

	// Watchdog: the whole run needs far less than a millisecond
	initial begin
		#1_000_000;
		mismatches++;
		wrap_up();
	end

	initial begin
		{psel, penable, pwrite, rx_stb, rx_brk} = 5'h0;
		{paddr, pwdata, rx_word} = 48'h0;
		{mismatches, checks_done, brk_cnt} = '0;
		rst_i = 1'b1;
		void'($urandom(31));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset value, then an unmapped place refused both ways
		rd(TRANSMITTER_STATUS_CONTROL, 32'hff, 32'h80);
		apb(1'b0, 8'h3c, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'h3c, $urandom, 32'h0, 1'b1);
		// Forced levels; release follows low so a stray frame aborts
		foreach (hl[i]) begin
			wr(TRANSMITTER_STATUS_CONTROL, {29'h0, hl[i], 1'b0});
			repeat (10) @(posedge clk_i);
			chk("so_pins", {29'h0, hl[i] == 2'b00, hl[i] == 2'b11,
				hl[i] != 2'b00 && hl[i][1]},
				{29'h0, so_oe_n, lb, so_oe_n ? 1'b0 : so});
		end
		// Word loaded before enable, then underrun and its interrupt
		wr(IMK, 32'h2);
		b = $urandom;
		bq.push_back(b);
		wr(DAT, {24'h0, b});
		wr(TRANSMITTER_STATUS_CONTROL, 32'h5);
		gap();
		rd(TRANSMITTER_STATUS_CONTROL, 32'hff, 32'hc5);
		irq_is(1'b1);
		rd(TRANSMITTER_STATUS_CONTROL, 32'hff, 32'h85);
		wr(IMK, 32'h0);
		irq_is(1'b0);
		rd(IST, 32'h2, 32'h2);
		wr(IST, 32'h1f);
		wr(IMK, 32'h2);
		irq_is(1'b0);
		// Third word buffered while the second shifts, then disable
		b = $urandom;
		bq.push_back(b);
		wr(DAT, {24'h0, b});
		repeat (16) @(posedge clk_i);
		rd(TRANSMITTER_STATUS_CONTROL, 32'h80, 32'h80);
		b = $urandom;
		wr(DAT, {24'h0, b});
		wr(TRANSMITTER_STATUS_CONTROL, 32'h24);
		gap();
		rd(TRANSMITTER_STATUS_CONTROL, 32'hff, 32'h34);
		chk("rx_on", 32'h1, {31'h0, rx_on});
		bq.push_back(b);
		wr(TRANSMITTER_STATUS_CONTROL, 32'h5);
		repeat (40) @(posedge clk_i);
		wr(TRANSMITTER_STATUS_CONTROL, 32'h4);
		gap();
		rd(TRANSMITTER_STATUS_CONTROL, 32'hff, 32'h94);
		// Break from idle, a word written during it follows the break
		wr(TRANSMITTER_STATUS_CONTROL, 32'h5);
		repeat (40) @(posedge clk_i);
		wr(IST, 32'h1f);
		brk_cnt = 0;
		wr(TRANSMITTER_STATUS_CONTROL, 32'hd);
		repeat (200) @(posedge clk_i);
		rd(IST, 32'h7, 32'h4);
		chk("break_chars", 32'h1, {31'h0, brk_cnt > 1});
		b = $urandom;
		bq.push_back(b);
		wr(DAT, {24'h0, b});
		wr(TRANSMITTER_STATUS_CONTROL, 32'h5);
		gap();
		// Sync idle with a zero character reads as breaks on the line
		wr(SCR, 32'h0);
		brk_cnt = 0;
		wr(CTL, 32'h1);
		rd(CTL, 32'h3, 32'h1);
		repeat (240) @(posedge clk_i);
		chk("sync_fill", 32'h1, {31'h0, brk_cnt > 1});
		// Idle disable with both levels clear releases the line
		wr(TRANSMITTER_STATUS_CONTROL, 32'h0);
		repeat (16) @(posedge clk_i);
		chk("halt_hiz", 32'h1, {31'h0, so_oe_n});
		// Break into a full buffer, then overrun followed by break
		wr(CTL, 32'h2);
		b = $urandom;
		rxp(b, 1'b0);
		rxp(8'h00, 1'b1);
		rd(RSR, 32'h6, 32'h0);
		rd(DAT, 32'hff, {24'h0, b});
		rd(RSR, 32'h6, 32'h4);
		b = $urandom;
		rxp(b, 1'b0);
		rxp(~b, 1'b0);
		rxp(8'h00, 1'b1);
		rd(DAT, 32'hff, {24'h0, b});
		rd(RSR, 32'h6, 32'h6);
		wr(CTL, 32'h0);
		chk("pending", 32'h0, bq.size());
		wrap_up();
	end
endmodule // test_usart_transmitter_break_control
